/* rtl/spimem_host.sv */
/*
 * Bus master end with its write data FIFO. Makes the link clock from
 * core_clk by a divider, frames commands and drives pause.
 * Assumes one command at a time on the user side.
 */
`default_nettype none
module spimem_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk, // Clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [W-1:0] in_data, // Word in
    output logic out_valid, // Word available
    input wire logic out_ready, // Word taken
    output logic [W-1:0] out_data // Word out
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem [0:D-1];
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    assign in_ready = (cnt != (PW+1)'(D));
    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= push ? PW'((32'(wp) + 1) % D) : wp;
            rp <= pop ? PW'((32'(rp) + 1) % D) : rp;
            cnt <= (PW+1)'(cnt + push - pop);
        end
    end
endmodule

module spimem_host (
    input wire logic core_clk, // Core clock
    input wire logic rst, // Asynchronous reset, active high
    spimem_if.host bus, // Link pins
    input wire logic cmd_valid, // Command offered
    output logic cmd_ready, // Idle, command taken
    input wire logic [7:0] cmd_op, // Command byte
    input wire logic [12:0] cmd_addr, // Start address
    input wire logic [7:0] cmd_len, // Data bytes after header
    input wire logic wr_valid, // Write byte offered
    output logic wr_ready, // FIFO has room
    input wire logic [7:0] wr_data, // Write byte
    output logic rd_valid, // Read byte pulse
    output logic [7:0] rd_data, // Read byte
    input wire logic pause_req, // Request pause
    input wire logic protect_n // Level for the protect pin
);
    import spimem_pkg::*;

    typedef enum logic [4:0] {
        HS_IDLE = 5'h01,
        HS_LOAD = 5'h02,
        HS_SHIFT = 5'h04,
        HS_END = 5'h08,
        HS_GAP = 5'h10
    } spimem_hstate_e;

    spimem_hstate_e state;
    logic [7:0] op;
    logic [12:0] addr;
    logic [7:0] len;
    logic [1:0] hdr_idx;
    logic [1:0] hdr_len;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [2:0] bitn;
    logic [4:0] div;
    logic data_rd;
    logic s1, s2, s3, miso_f;
    logic sck_q, cs_q, mosi_q, hold_q, wp_q;
    logic f_valid;
    logic [7:0] f_data;

    wire tick = (div == SCK_HALF_LAST);
    wire op_rd = (op == OP_ARR_RD) || (op == OP_STAT_RD);
    wire hdr_more = (hdr_idx != hdr_len);
    wire [7:0] hdr_byte = (hdr_idx == 2'h0) ? op :
                          (hdr_idx == 2'h1) ? {3'h0, addr[12:8]} : addr[7:0];
    wire pop = (state == HS_LOAD) && !hdr_more && len != 8'h00 && !op_rd;
    wire holding = !hold_q;
    wire div_run = (state != HS_IDLE) && (state != HS_LOAD) && !holding;

    assign cmd_ready = (state == HS_IDLE);
    assign bus.sck = sck_q;
    assign bus.cs_n = cs_q;
    assign bus.mosi = mosi_q;
    assign bus.hold_n = hold_q;
    assign bus.wp_n = wp_q;

    spimem_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .clk(core_clk),
        .rst(rst),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_data),
        .out_valid(f_valid),
        .out_ready(pop),
        .out_data(f_data)
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {s1, s2, s3, miso_f} <= 4'hF;
        end else begin
            {s1, s2, s3} <= {bus.miso_line, s1, s2};
            miso_f <= (s2 == s3) ? s3 : miso_f;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div <= 5'h00;
        end else begin
            div <= (!div_run || tick) ? 5'h00 : 5'(div + 1'b1);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= HS_IDLE;
            {op, tx, rx, len, rd_data} <= 40'h0;
            addr <= 13'h0000;
            {hdr_idx, hdr_len, bitn} <= 7'h00;
            {data_rd, rd_valid, sck_q, mosi_q} <= 4'h0;
            {cs_q, hold_q, wp_q} <= 3'h7;
        end else begin
            rd_valid <= 1'b0;
            wp_q <= protect_n;
            case (state)
                HS_IDLE: if (cmd_valid) begin
                    op <= cmd_op;
                    addr <= cmd_addr;
                    len <= cmd_len;
                    hdr_idx <= 2'h0;
                    hdr_len <= (cmd_op == OP_ARR_RD || cmd_op == OP_ARR_WR) ?
                               HDR_ADDR_LEN : HDR_CMD_LEN;
                    cs_q <= 1'b0;
                    state <= HS_LOAD;
                end
                HS_LOAD: if (hdr_more) begin
                    tx <= hdr_byte;
                    mosi_q <= hdr_byte[7];
                    hdr_idx <= 2'(hdr_idx + 1'b1);
                    data_rd <= 1'b0;
                    state <= HS_SHIFT;
                end else if (len == 8'h00) begin
                    state <= HS_END;
                end else if (op_rd || f_valid) begin
                    tx <= op_rd ? 8'h00 : f_data;
                    mosi_q <= op_rd ? 1'b0 : f_data[7];
                    data_rd <= op_rd;
                    len <= 8'(len - 1'b1);
                    state <= HS_SHIFT;
                end
                HS_SHIFT: if (!sck_q && holding) begin
                    hold_q <= !pause_req ? 1'b1 : 1'b0;
                end else if (!sck_q && pause_req) begin
                    hold_q <= 1'b0;
                end else if (tick && !sck_q) begin
                    sck_q <= 1'b1;
                    rx <= {rx[6:0], miso_f};
                end else if (tick) begin
                    sck_q <= 1'b0;
                    bitn <= 3'(bitn + 1'b1);
                    tx <= {tx[6:0], 1'b0};
                    mosi_q <= tx[6];
                    if (bitn == BIT_LAST) begin
                        rd_valid <= data_rd;
                        rd_data <= rx;
                        state <= HS_LOAD;
                    end
                end
                HS_END: if (tick) begin
                    cs_q <= 1'b1;
                    state <= HS_GAP;
                end
                HS_GAP: if (tick) begin
                    state <= HS_IDLE;
                end
                default: state <= HS_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* rtl/spimem_pkg.sv */
/*
 * Shared constants for the serial memory link: command codes, address
 * layout, status bit positions, protection bounds and host timing.
 * Assumes both ends and the bench import it.
 */
`default_nettype none
package spimem_pkg;
    localparam int ADDR_W = 13;
    localparam int MEM_DEPTH = 8192;
    localparam logic [ADDR_W-1:0] ADDR_FIRST = 13'h0000;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 13'h1FFF;
    localparam logic [ADDR_W-1:0] PROT_QTR_BASE = 13'h1800;
    localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 13'h1000;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_ARR_RD = 8'h03;
    localparam logic [7:0] OP_ARR_WR = 8'h02;
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QTR = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam int SR_LOCK_BIT = 7;
    localparam int SR_BPHI_BIT = 3;
    localparam int SR_BPLO_BIT = 2;
    localparam int SR_LATCH_BIT = 1;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] HDR_ADDR_LEN = 2'h3;
    localparam logic [1:0] HDR_CMD_LEN = 2'h1;
    localparam int CORE_PERIOD_NS = 5;
    localparam int SCK_HALF_NS = 100;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam logic [4:0] SCK_HALF_LAST = 5'(SCK_HALF_CYC - 1);
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 8;
endpackage
`default_nettype wire

/* rtl/spimem_if.sv */
/*
 * Link between the serial memory and its bus master.
 * Assumes a pull-up on the data return line when the memory releases it.
 */
`default_nettype none
interface spimem_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic hold_n;
    logic wp_n;
    logic miso;
    logic miso_oe;
    wire miso_line;
    assign miso_line = miso_oe ? miso : 1'b1;
    modport dev (input sck, input cs_n, input mosi, input hold_n, input wp_n,
                 output miso, output miso_oe);
    modport host (output sck, output cs_n, output mosi, output hold_n, output wp_n,
                  input miso_line);
endinterface
`default_nettype wire

/* rtl/spimem_dev.sv */
/*
 * Serial memory end: 8192 x 8 array, command decode, sequential read and
 * write, pause, write latch and block protection.
 * Assumes it is clocked by the link clock and that the master frames each
 * command with chip select and moves pause only while the clock is low.
 */
// Summary of operation
// - Master sends latch set, then write frame
// - Top three address bits dropped, thirteen used
// - Address advances per byte, wraps to zero
// - Each write byte stored at eighth bit
// - Write data shifts in MSB first
// - Chip select rise ends write, partial dropped
// - Master sends read command and address
// - Input line ignored after read header
// - One read bit per clock, MSB first
// - Chip select rise ends read
// - Pause low freezes operation in place
// - Pause high resumes exactly where stopped
// - Clock ignored while pause is held
// - Full lock rejects protect writes; array writes follow the protect code
// - Fixed command byte encodings
// - Sample on rise, drive on fall
// - Write frame end clears write latch
// - Protect code selects protected upper range
`default_nettype none
module spimem_dev (
    spimem_if.dev bus, // Link pins
    input wire logic rst, // Asynchronous reset, active high
    output logic [7:0] status, // Live status byte
    output logic write_latch // Write latch state
);
    import spimem_pkg::*;

    typedef enum logic [7:0] {
        SM_CMD = 8'h01,
        SM_ADH = 8'h02,
        SM_ADL = 8'h04,
        SM_WDAT = 8'h08,
        SM_RDAT = 8'h10,
        SM_SRD = 8'h20,
        SM_SWR = 8'h40,
        SM_DONE = 8'h80
    } spimem_state_e;

    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a);
        step_addr = (a == ADDR_LAST) ? ADDR_FIRST : ADDR_W'(a + 1'b1);
    endfunction

    function automatic logic is_protected(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
        case (bp)
            BP_QTR: is_protected = (a >= PROT_QTR_BASE);
            BP_HALF: is_protected = (a >= PROT_HALF_BASE);
            BP_ALL: is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction

    logic [7:0] mem [0:MEM_DEPTH-1];
    spimem_state_e state;
    spimem_state_e next_state;
    logic [2:0] bit_cnt;
    logic [7:0] sh;
    logic [7:0] out_sh;
    logic [ADDR_W-1:0] addr;
    logic is_read;
    logic set_tog;
    logic clr_tog;
    logic clr_req;
    logic lock_en;
    logic [1:0] bp;
    logic miso_q;
    logic oe_q;

    wire frame_rst = rst | bus.cs_n;
    wire [7:0] next_byte = {sh[6:0], bus.mosi};
    wire byte_end = bus.hold_n & (bit_cnt == BIT_LAST);
    wire [ADDR_W-1:0] hdr_addr = {addr[12:8], next_byte};
    wire [ADDR_W-1:0] addr_inc = step_addr(addr);
    wire status_locked = lock_en & ~bus.wp_n;
    wire wr_fire = byte_end && state == SM_WDAT && write_latch && !is_protected(bp, addr);
    wire sr_fire = byte_end && state == SM_SWR && write_latch && !status_locked;
    wire op_is_wr = (next_byte == OP_ARR_WR) || (next_byte == OP_STAT_WR) ||
                    (next_byte == OP_LATCH_CLR);

    assign write_latch = set_tog ^ clr_tog;
    assign status = {lock_en, 3'h0, bp, write_latch, 1'b0};
    assign bus.miso = miso_q;
    // Release the line at once on a pause, since no clock edge follows it
    assign bus.miso_oe = oe_q & bus.hold_n & ~bus.cs_n;

    always_comb begin
        next_state = state;
        case (state)
            SM_CMD: begin
                if (next_byte == OP_ARR_RD || next_byte == OP_ARR_WR) begin
                    next_state = SM_ADH;
                end else if (next_byte == OP_STAT_RD) begin
                    next_state = SM_SRD;
                end else if (next_byte == OP_STAT_WR) begin
                    next_state = SM_SWR;
                end else begin
                    next_state = SM_DONE;
                end
            end
            SM_ADH: next_state = SM_ADL;
            SM_ADL: next_state = is_read ? SM_RDAT : SM_WDAT;
            SM_WDAT: next_state = SM_WDAT;
            SM_RDAT: next_state = SM_RDAT;
            SM_SRD: next_state = SM_DONE;
            SM_SWR: next_state = SM_DONE;
            SM_DONE: next_state = SM_DONE;
            default: next_state = SM_DONE;
        endcase
    end

    // Frame logic; chip select high resets bit and byte position
    always_ff @(posedge bus.sck or posedge frame_rst) begin
        if (frame_rst) begin
            state <= SM_CMD;
            bit_cnt <= BIT_FIRST;
            sh <= 8'h00;
            is_read <= 1'b0;
        end else if (bus.hold_n) begin
            bit_cnt <= 3'(bit_cnt + 1'b1);
            sh <= next_byte;
            if (byte_end) begin
                state <= next_state;
            end
            if (byte_end && state == SM_CMD) begin
                is_read <= (next_byte == OP_ARR_RD);
            end
        end
    end

    // Address and read data; input bits are not used once reading starts
    always_ff @(posedge bus.sck or posedge rst) begin
        if (rst) begin
            addr <= ADDR_FIRST;
            out_sh <= 8'h00;
        end else if (byte_end) begin
            case (state)
                SM_CMD: out_sh <= status;
                SM_ADH: addr <= {next_byte[4:0], 8'h00};
                SM_ADL: begin
                    addr <= hdr_addr;
                    out_sh <= mem[hdr_addr];
                end
                SM_RDAT: begin
                    addr <= addr_inc;
                    out_sh <= mem[addr_inc];
                end
                SM_WDAT: addr <= addr_inc;
                default: out_sh <= out_sh;
            endcase
        end
    end

    always_ff @(posedge bus.sck) begin
        if (wr_fire) begin
            mem[addr] <= next_byte;
        end
    end

    // Status bits; reset stands in for their stored power-up value
    always_ff @(posedge bus.sck or posedge rst) begin
        if (rst) begin
            lock_en <= 1'b0;
            bp <= BP_NONE;
        end else if (sr_fire) begin
            lock_en <= next_byte[SR_LOCK_BIT];
            bp <= {next_byte[SR_BPHI_BIT], next_byte[SR_BPLO_BIT]};
        end
    end

    // Latch set side; the clear side lives on the chip select edge
    always_ff @(posedge bus.sck or posedge rst) begin
        if (rst) begin
            set_tog <= 1'b0;
            clr_req <= 1'b0;
        end else if (byte_end && state == SM_CMD) begin
            clr_req <= op_is_wr;
            if (next_byte == OP_LATCH_SET) begin
                set_tog <= ~clr_tog;
            end
        end
    end

    always_ff @(posedge bus.cs_n or posedge rst) begin
        if (rst) begin
            clr_tog <= 1'b0;
        end else if (clr_req) begin
            clr_tog <= set_tog;
        end
    end

    // Read data changes on the falling edge, one bit per clock
    always_ff @(negedge bus.sck or posedge frame_rst) begin
        if (frame_rst) begin
            miso_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (bus.hold_n) begin
            miso_q <= out_sh[3'(BIT_LAST - bit_cnt)];
            oe_q <= (state == SM_RDAT) || (state == SM_SRD);
        end
    end
endmodule
`default_nettype wire

/* dv/spimem_props.sv */
/*
 * Link checker for the serial memory and its master, watching the pins.
 * Assumes core_clk clocks the master, which drives the clock, select, data out, pause and protect lines.
 */
`default_nettype none
module spimem_props (
    input wire logic core_clk, // Core clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic sck, // Link clock
    input wire logic cs_n, // Frame select
    input wire logic mosi, // Master data
    input wire logic hold_n, // Pause
    input wire logic wp_n, // Protect pin
    input wire logic miso, // Memory data
    input wire logic miso_oe, // Memory drive enable
    input wire logic miso_line // Resolved return line
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic sck_q;
    logic [2:0] bit_cnt;
    wire sck_rise = sck & ~sck_q;
    wire [2:0] next_bit_cnt = cs_n ? 3'h0 : bit_cnt + {2'h0, sck_rise};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sck_q <= 1'b0;
            bit_cnt <= 3'h0;
        end else begin
            sck_q <= sck;
            bit_cnt <= next_bit_cnt;
        end
    end

    sequence s_hold_in;
        $fell(hold_n) && !cs_n;
    endsequence
    sequence s_rise;
        $rose(sck) && !cs_n;
    endsequence
    property p_high_phase;
        s_rise |-> ##19 sck ##1 !sck;
    endproperty

    chk_oe_deselect: assert property (cs_n |-> !miso_oe)
        else $error("memory drives line while deselected");
    chk_oe_paused: assert property (!hold_n |-> !miso_oe)
        else $error("memory drives line while paused");
    chk_line_pullup: assert property (!miso_oe |-> miso_line)
        else $error("released line not pulled high");
    chk_hold_sck_low: assert property ($changed(hold_n) |-> !sck)
        else $error("pause moved while clock high");
    chk_sck_frozen: assert property (!hold_n |-> $stable(sck))
        else $error("link clock moved during pause");
    chk_pause_quiet: assert property (s_hold_in |-> !sck && !miso_oe)
        else $error("pause entry not quiet");
    chk_mosi_on_low: assert property ($changed(mosi) |-> !sck)
        else $error("master data moved while clock high");
    chk_miso_on_fall: assert property (
        !cs_n && !$past(cs_n) && $changed(miso) |-> $fell(sck))
        else $error("memory data moved off a falling edge");
    chk_oe_on_fall: assert property (
        $rose(miso_oe) && $past(hold_n) |-> $fell(sck))
        else $error("memory drive enabled off a falling edge");
    chk_high_phase: assert property (p_high_phase)
        else $error("clock high phase not twenty cycles");
    chk_whole_bytes: assert property ($rose(cs_n) |-> bit_cnt == 3'h0)
        else $error("frame ended inside a byte");
    chk_idle_low: assert property (cs_n |-> !sck)
        else $error("link clock high outside a frame");
endmodule
`default_nettype wire

/* dv/tb_spi_memory_read_write_hold.sv */
/*
 * Bench joining the master and memory ends through the link interface.
 * Assumes the master takes one command at a time on its user side.
 */
`default_nettype none
module tb_spi_memory_read_write_hold;
    timeunit 1ns;
    timeprecision 100ps;
    import spimem_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_op = 8'h00;
    logic [12:0] cmd_addr = 13'h0000;
    logic [7:0] cmd_len = 8'h00;
    logic wr_valid = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic pause_req = 1'b0;
    logic protect_n = 1'b1;
    logic cmd_ready, wr_ready, rd_valid, write_latch;
    logic saw_hold = 1'b0;
    logic [7:0] rd_data, status;
    logic [7:0] rdq [$];
    logic [7:0] mem_m [0:MEM_DEPTH-1];
    logic [1:0] bp_m = BP_NONE;
    int err_count = 0;
    int num_checks = 0;

    spimem_if spimem_if_i ();
    spimem_host spimem_host_i (.core_clk(core_clk), .rst(rst), .bus(spimem_if_i),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_data(rd_data), .pause_req(pause_req), .protect_n(protect_n));
    spimem_dev spimem_dev_i (.bus(spimem_if_i), .rst(rst), .status(status),
        .write_latch(write_latch));
    spimem_props spimem_props_i (.core_clk(core_clk), .rst(rst), .sck(spimem_if_i.sck),
        .cs_n(spimem_if_i.cs_n), .mosi(spimem_if_i.mosi), .hold_n(spimem_if_i.hold_n),
        .wp_n(spimem_if_i.wp_n), .miso(spimem_if_i.miso), .miso_oe(spimem_if_i.miso_oe),
        .miso_line(spimem_if_i.miso_line));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (rd_valid === 1'b1) rdq.push_back(rd_data);
        if (spimem_if_i.hold_n === 1'b0) saw_hold <= 1'b1;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic step();
        @(posedge core_clk);
        #1;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 20000) begin
            step();
            n++;
        end
        if (n >= 20000) begin
            err_count++;
            $display("[FAIL] %0t master stuck busy", $time);
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [12:0] a, input logic [7:0] len);
        wait_idle();
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_len = len;
        step();
        cmd_valid = 1'b0;
        step();
        wait_idle();
    endtask

    function automatic logic prot(input logic [1:0] bp, input logic [12:0] a);
        return bp == BP_ALL || (bp == BP_HALF && a >= PROT_HALF_BASE) ||
            (bp == BP_QTR && a >= PROT_QTR_BASE);
    endfunction

    task automatic wr_arr(input logic [12:0] a, input int n, input logic [7:0] s,
            input logic en);
        logic [12:0] p;
        if (en) begin
            cmd(OP_LATCH_SET, 13'h0000, 8'h00);
            chk1(write_latch, 1'b1);
        end
        for (int i = 0; i < n; i++) begin
            wr_data = 8'(s + 8'(i * 19));
            wr_valid = 1'b1;
            step();
        end
        wr_valid = 1'b0;
        if (n == FIFO_D) chk1(wr_ready, 1'b0);
        cmd(OP_ARR_WR, a, 8'(n));
        chk1(write_latch, 1'b0);
        for (int i = 0; i < n; i++) begin
            p = a + 13'(i);
            if (en && !prot(bp_m, p)) mem_m[p] = 8'(s + 8'(i * 19));
        end
    endtask

    task automatic rd_arr(input logic [12:0] a, input int n);
        rdq.delete();
        cmd(OP_ARR_RD, a, 8'(n));
        chk8(8'(rdq.size()), 8'(n));
        for (int i = 0; i < n && i < rdq.size(); i++) begin
            chk8(rdq[i], mem_m[a + 13'(i)]);
        end
    endtask

    task automatic st_wr(input logic [7:0] v);
        cmd(OP_LATCH_SET, 13'h0000, 8'h00);
        wr_data = v;
        wr_valid = 1'b1;
        step();
        wr_valid = 1'b0;
        cmd(OP_STAT_WR, 13'h0000, 8'h01);
    endtask

    task automatic st_rd(input logic [7:0] e);
        rdq.delete();
        cmd(OP_STAT_RD, 13'h0000, 8'h01);
        chk8(8'(rdq.size()), 8'h01);
        if (rdq.size() > 0) chk8(rdq[0], e);
        chk8(status, e);
    endtask

    initial begin
        #(80000 * CORE_PERIOD_NS);
        err_count++;
        $display("[FAIL] %0t run did not finish in time", $time);
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge core_clk);
        #1 rst = 1'b0;
        step();
        chk8(status, 8'h00);
        chk1(spimem_if_i.miso_line, 1'b1);
        wr_arr(13'h1FFC, FIFO_D, 8'h51, 1'b1);
        rd_arr(13'h1FFC, 8);
        $display("test wrap write and read done");
        wr_arr(13'h0001, 2, 8'hA0, 1'b0);
        rd_arr(13'h0000, 4);
        $display("test write without latch done");
        fork
            rd_arr(13'h1FFE, 4);
            begin
                repeat (1500) step();
                pause_req = 1'b1;
                repeat (200) step();
                pause_req = 1'b0;
            end
        join
        chk1(saw_hold, 1'b1);
        $display("test pause in read done");
        for (int c = 0; c < 4; c++) begin
            st_wr(8'(c) << 2);
            bp_m = 2'(c);
            st_rd(8'(c) << 2);
            wr_arr(13'h17FF, 2, 8'(c * 16 + 5), 1'b1);
            rd_arr(13'h17FF, 2);
            wr_arr(13'h0FFF, 2, 8'(c * 16 + 9), 1'b1);
            rd_arr(13'h0FFF, 2);
        end
        $display("test protect codes done");
        st_wr(8'h8C);
        bp_m = BP_ALL;
        protect_n = 1'b0;
        repeat (2) step();
        st_wr(8'h00);
        st_rd(8'h8C);
        wr_arr(13'h17FF, 1, 8'h77, 1'b1);
        rd_arr(13'h17FF, 1);
        protect_n = 1'b1;
        repeat (2) step();
        st_wr(8'h00);
        bp_m = BP_NONE;
        st_rd(8'h00);
        $display("test full lock done");
        report_and_stop();
    end
endmodule
`default_nettype wire
